//--- verilog/gcf_ctrl.v
`timescale 1ns/10ps
`default_nettype none
`include "gcf_map.vh"
// ----------------------------------------
// Gate command and fault feedback control
// ----------------------------------------
module gcf_ctrl #(
  parameter W             = `GCF_CNT_W,
  parameter TON_PROP_CYC  = `GCF_TON_PROP_CYC,
  parameter TOFF_PROP_CYC = `GCF_TOFF_PROP_CYC,
  parameter ACK_CYC       = `GCF_ACK_CYC,
  parameter RES_CYC       = `GCF_RES_CYC,
  parameter SC_SHUT_CYC   = `GCF_SC_SHUT_CYC,
  parameter BLK_CYC       = `GCF_BLK_CYC
) (
  input  wire CLK_SYS,
  input  wire RSTN,
  input  wire COMMAND_LIGHT_INPUT,
  input  wire POSITIVE_RAIL_OK,
  input  wire NEGATIVE_RAIL_OK,
  input  wire DESAT_DETECT,
  output reg  GATE_ON,
  output reg  GATE_NEGATIVE_DRIVE,
  output reg  STATUS_LIGHT_OUTPUT
);
  // ----------------------------------------
  // Fault state machine codes (one-hot)
  // ----------------------------------------
  localparam [3:0] ST_IDLE  = 4'h1;
  localparam [3:0] ST_CHECK = 4'h2;
  localparam [3:0] ST_SHUT  = 4'h4;
  localparam [3:0] ST_BLOCK = 4'h8;

  // Timer loads cut to counter width
  localparam [W-1:0] TON_V  = TON_PROP_CYC[W-1:0];
  localparam [W-1:0] TOFF_V = TOFF_PROP_CYC[W-1:0];
  localparam [W-1:0] ACK_V  = ACK_CYC[W-1:0];
  localparam [W-1:0] RES_V  = RES_CYC[W-1:0];
  localparam [W-1:0] SHUT_V = SC_SHUT_CYC[W-1:0];
  localparam [W-1:0] BLK_V  = BLK_CYC[W-1:0];
  // Rest of blocking after shutdown; never below one cycle
  localparam [W-1:0] BLK_REST_V = (BLK_CYC > SC_SHUT_CYC) ?
                                  (BLK_V - SHUT_V) : {{(W-1){1'b0}}, 1'b1};

  wire         cmd_s;
  reg          cmd_prev_q;
  wire         rise;
  wire         fall;
  wire         edge_any;
  wire         undervoltage_lockout;
  reg  [3:0]   st_q;
  reg  [3:0]   st_d;
  reg          cmd_pend_q;
  reg          gate_req_q;
  reg          gate_req_d;
  wire         prop_done;
  wire         ack_busy;
  wire         flt_done;
  reg          flt_load;
  reg  [W-1:0] flt_val;
  reg          gate_on_d;
  reg          neg_drv_d;
  reg          status_d;

  // ----------------------------------------
  // Shared decodes
  // ----------------------------------------
  // True while a short-circuit fault is in shutdown delay or blocking
  function fault_hold;
    input [3:0] st;
    begin
      fault_hold = (st == ST_SHUT) || (st == ST_BLOCK);
    end
  endfunction

  // Propagation load for an edge: on and off delays set separately
  function [W-1:0] prop_load;
    input is_rise;
    begin
      if (is_rise) begin
        prop_load = TON_V;
      end else begin
        prop_load = TOFF_V;
      end
    end
  endfunction

  // ----------------------------------------
  // Command input synchroniser and edge detect
  // ----------------------------------------
  gcf_sync u_sync_cmd (
    .CLK_SYS (CLK_SYS),
    .RSTN    (RSTN),
    .d       (COMMAND_LIGHT_INPUT),
    .q       (cmd_s)
  );

  // Previous synchronised command level
  always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      cmd_prev_q <= 1'b0;
    end else begin
      cmd_prev_q <= cmd_s;
    end
  end

  assign rise = cmd_s & ~cmd_prev_q;
  assign fall = ~cmd_s & cmd_prev_q;

  // Either edge starts the delay and the acknowledge
  assign edge_any = rise | fall;

  // Undervoltage until both rails are good, power-up included
  assign undervoltage_lockout = ~(POSITIVE_RAIL_OK & NEGATIVE_RAIL_OK);

  // ----------------------------------------
  // Propagation delay of command to gate
  // ----------------------------------------
  gcf_timer #(.W(W)) u_prop (
    .CLK_SYS (CLK_SYS),
    .RSTN    (RSTN),
    .load    (edge_any),
    .value   (prop_load(rise)),
    .cancel  (undervoltage_lockout),      // Commands ignored in lockout
    .busy    (),
    .done    (prop_done)
  );

  // Pending command level, latched on each edge
  always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      cmd_pend_q <= 1'b0;
    end else if (edge_any) begin
      cmd_pend_q <= rise;
    end
  end

  // ----------------------------------------
  // Acknowledge pulse timer
  // ----------------------------------------
  gcf_timer #(.W(W)) u_ack (
    .CLK_SYS (CLK_SYS),
    .RSTN    (RSTN),
    .load    (edge_any),
    .value   (ACK_V),
    .cancel  (1'b0),
    .busy    (ack_busy),
    .done    ()
  );

  // ----------------------------------------
  // Short-circuit fault timer
  // ----------------------------------------
  gcf_timer #(.W(W)) u_flt (
    .CLK_SYS (CLK_SYS),
    .RSTN    (RSTN),
    .load    (flt_load),
    .value   (flt_val),
    .cancel  (1'b0),
    .busy    (),
    .done    (flt_done)
  );

  // Next state and timer loads; one fault timer is reloaded at each
  // step: response time, then shutdown delay, then rest of blocking.
  // A turn-off during the response window drops the check.
  always @* begin
    st_d     = st_q;
    flt_load = 1'b0;
    flt_val  = RES_V;
    case (st_q)
      // Waits for a completed turn-on
      ST_IDLE: begin
        if (prop_done && cmd_pend_q && !undervoltage_lockout) begin
          st_d     = ST_CHECK;
          flt_load = 1'b1;
          flt_val  = RES_V;
        end
      end
      // Response time runs; desaturation sampled at its end
      ST_CHECK: begin
        if (!gate_req_q) begin
          st_d = ST_IDLE;
        end else if (flt_done) begin
          if (DESAT_DETECT) begin
            st_d     = ST_SHUT;
            flt_load = 1'b1;
            flt_val  = SHUT_V;
          end else begin
            st_d = ST_IDLE;
          end
        end
      end
      // Fault shown; gate stays on until the delay ends
      ST_SHUT: begin
        if (flt_done) begin
          st_d     = ST_BLOCK;
          flt_load = 1'b1;
          flt_val  = BLK_REST_V;
        end
      end
      // Gate off, light off until blocking ends
      ST_BLOCK: begin
        if (flt_done) begin
          st_d = ST_IDLE;
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  // Fault state register
  always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      st_q <= ST_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------
  // Gate request, shut on fault or undervoltage
  // ----------------------------------------
  // Next request: lockout first, then fault shutdown, then command
  always @* begin
    gate_req_d = gate_req_q;
    if (undervoltage_lockout) begin
      gate_req_d = 1'b0;
    end else if (st_q == ST_SHUT && flt_done) begin
      gate_req_d = 1'b0;
    end else if (prop_done) begin
      // Turn-on ignored while blocked; needs fresh edge
      if (!cmd_pend_q) begin
        gate_req_d = 1'b0;
      end else if (!fault_hold(st_q)) begin
        gate_req_d = 1'b1;
      end
    end
  end

  // Gate request register
  always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      gate_req_q <= 1'b0;
    end else begin
      gate_req_q <= gate_req_d;
    end
  end

  // ----------------------------------------
  // Output next values
  // ----------------------------------------
  // Lockout wins over any command and any fault timing
  always @* begin
    gate_on_d = gate_req_q & ~undervoltage_lockout;
    neg_drv_d = undervoltage_lockout;
    // Lit only with good rails and no ack blanking
    status_d  = ~undervoltage_lockout & ~ack_busy;
    // Fault and blocking keep the light dark
    if (fault_hold(st_q)) begin
      status_d = 1'b0;
    end
  end

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  // Outputs come from flops; reset values are the lockout ones
  always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      GATE_ON             <= 1'b0;
      GATE_NEGATIVE_DRIVE <= 1'b1;
      STATUS_LIGHT_OUTPUT <= 1'b0;
    end else begin
      GATE_ON             <= gate_on_d;
      GATE_NEGATIVE_DRIVE <= neg_drv_d;
      STATUS_LIGHT_OUTPUT <= status_d;
    end
  end
endmodule
`default_nettype wire

//--- verilog/gcf_map.vh
`ifndef GCF_MAP_VH
`define GCF_MAP_VH
// ----------------------------------------
// Clock and timing figures
// ----------------------------------------
`define GCF_CLK_PERIOD_NS        25
// Times in ns (plain defaults, tune per part)
`define GCF_TON_PROP_NS          800
`define GCF_TOFF_PROP_NS         800
`define GCF_ACK_NS               1000
`define GCF_RES_NS               10000
`define GCF_SC_SHUT_NS           1000
`define GCF_BLK_NS               9000000
// Cycle counts: least times round up
`define GCF_CYC_UP(ns)           (((ns) + `GCF_CLK_PERIOD_NS - 1) / `GCF_CLK_PERIOD_NS)
`define GCF_TON_PROP_CYC         `GCF_CYC_UP(`GCF_TON_PROP_NS)
`define GCF_TOFF_PROP_CYC        `GCF_CYC_UP(`GCF_TOFF_PROP_NS)
`define GCF_ACK_CYC              `GCF_CYC_UP(`GCF_ACK_NS)
`define GCF_RES_CYC              `GCF_CYC_UP(`GCF_RES_NS)
`define GCF_SC_SHUT_CYC          `GCF_CYC_UP(`GCF_SC_SHUT_NS)
`define GCF_BLK_CYC              `GCF_CYC_UP(`GCF_BLK_NS)
// Counter width
`define GCF_CNT_W                20
`endif

//--- verilog/gcf_sync.v
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Two-flop synchroniser
// ----------------------------------------
module gcf_sync (
  input  wire CLK_SYS,
  input  wire RSTN,
  input  wire d,
  output wire q
);
  reg meta_q;
  reg sync_q;

  // First flop read only by the second
  always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;
endmodule
`default_nettype wire

//--- verilog/gcf_timer.v
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Load-and-count-down timer, done pulse at zero
// ----------------------------------------
module gcf_timer #(
  parameter W = 20
) (
  input  wire         CLK_SYS,
  input  wire         RSTN,
  input  wire         load,
  input  wire [W-1:0] value,
  input  wire         cancel,
  output wire         busy,
  output reg          done
);
  reg [W-1:0] cnt_q;

  // Load wins over cancel; done as the count steps from one to zero
  always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      cnt_q <= {W{1'b0}};
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      if (load) begin
        cnt_q <= value;
      end else if (cancel) begin
        cnt_q <= {W{1'b0}};
      end else if (cnt_q != {W{1'b0}}) begin
        cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
        if (cnt_q == {{(W-1){1'b0}}, 1'b1}) begin
          done <= 1'b1;
        end
      end
    end
  end

  assign busy = (cnt_q != {W{1'b0}});
endmodule
`default_nettype wire

//--- verif/gcf_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Controller end of the command fibre
// ----------------------------------------
module gcf_host_model (
  input  wire logic clk,
  input  wire logic want_on,
  output var  logic cmd_light
);
  // Light asks for gate on, dark for off; re-arm is a fresh rise
  always @(posedge clk) begin
    cmd_light <= want_on;
  end
endmodule
`default_nettype wire

//--- verif/gcf_ctrl_asserts.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Port checker
// ----------------------------------------
module gcf_ctrl_chk (
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire logic COMMAND_LIGHT_INPUT,
  input wire logic POSITIVE_RAIL_OK,
  input wire logic NEGATIVE_RAIL_OK,
  input wire logic DESAT_DETECT,
  input wire logic GATE_ON,
  input wire logic GATE_NEGATIVE_DRIVE,
  input wire logic STATUS_LIGHT_OUTPUT
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);
  wire logic rail_ok = POSITIVE_RAIL_OK && NEGATIVE_RAIL_OK;
  // Desaturation held across the turn-on check
  sequence s_sc;
    ($rose(GATE_ON) && DESAT_DETECT) ##1 DESAT_DETECT [*8] ##1 DESAT_DETECT [*4];
  endsequence
  property p_uv; !rail_ok |=> !GATE_ON && GATE_NEGATIVE_DRIVE; endproperty
  property p_uvs; !rail_ok |=> !STATUS_LIGHT_OUTPUT; endproperty
  property p_ack; $changed(COMMAND_LIGHT_INPUT) |-> ##[1:5] !STATUS_LIGHT_OUTPUT; endproperty
  property p_fast; $rose(COMMAND_LIGHT_INPUT) && !GATE_ON |=> !GATE_ON [*3]; endproperty
  property p_off; $fell(COMMAND_LIGHT_INPUT) |-> ##[4:40] !GATE_ON; endproperty
  property p_sc; s_sc |-> ##[0:3] !STATUS_LIGHT_OUTPUT; endproperty
  property p_shut; s_sc |-> ##[0:10] !GATE_ON; endproperty
  property p_blk; s_sc |-> ##12 !STATUS_LIGHT_OUTPUT ##[1:24] STATUS_LIGHT_OUTPUT; endproperty
  a_uv: assert property (p_uv) else $error("gate not forced off");
  a_uvs: assert property (p_uvs) else $error("status lit in lockout");
  a_ack: assert property (p_ack) else $error("edge not acknowledged");
  a_fast: assert property (p_fast) else $error("turn-on too early");
  a_off: assert property (p_off) else $error("turn-off missing");
  a_sc: assert property (p_sc) else $error("fault not shown");
  a_shut: assert property (p_shut) else $error("no fault shutdown");
  a_blk: assert property (p_blk) else $error("blocking span wrong");
  c_sc: cover property (s_sc);
  c_uv: cover property (!rail_ok ##1 rail_ok);
  c_on: cover property ($rose(GATE_ON));
endmodule
bind gcf_ctrl gcf_ctrl_chk gcf_ctrl_chk_i (.CLK_SYS(CLK_SYS), .RSTN(RSTN),
  .COMMAND_LIGHT_INPUT(COMMAND_LIGHT_INPUT), .POSITIVE_RAIL_OK(POSITIVE_RAIL_OK),
  .NEGATIVE_RAIL_OK(NEGATIVE_RAIL_OK), .DESAT_DETECT(DESAT_DETECT), .GATE_ON(GATE_ON),
  .GATE_NEGATIVE_DRIVE(GATE_NEGATIVE_DRIVE), .STATUS_LIGHT_OUTPUT(STATUS_LIGHT_OUTPUT));
`default_nettype wire

//--- verif/tb_gcf_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
`include "gcf_map.vh"
// ----------------------------------------
// Bench for the gate control block
// ----------------------------------------
module tb_gcf_ctrl;
  logic        clk, rstn, want, p_ok, n_ok, desat;
  wire logic   cmd, gate_on, neg_drv, status;
  int          failures, tests_run, i;
  logic [31:0] rs;
  logic        qe[$];
  gcf_host_model gcf_host_model_i (.clk(clk), .want_on(want), .cmd_light(cmd));
  // Short timings; turn-off delay keeps its default so both delays differ
  gcf_ctrl #(.TON_PROP_CYC(3), .ACK_CYC(4), .RES_CYC(10),
    .SC_SHUT_CYC(3), .BLK_CYC(20)) gcf_ctrl_i (.CLK_SYS(clk), .RSTN(rstn),
    .COMMAND_LIGHT_INPUT(cmd), .POSITIVE_RAIL_OK(p_ok), .NEGATIVE_RAIL_OK(n_ok),
    .DESAT_DETECT(desat), .GATE_ON(gate_on), .GATE_NEGATIVE_DRIVE(neg_drv),
    .STATUS_LIGHT_OUTPUT(status));
  // Pseudo-random spacing source
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  // Compare and count
  task automatic chk(input logic seen, input logic exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Wait cycles, then settle past the edge
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task end_sim;
    $display("tests_run=%0d failures=%0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Watchdog
  initial begin
    #60000;
    failures++;
    end_sim;
  end
  // Main sequence
  initial begin
    rstn = 1'b0; want = 1'b0; p_ok = 1'b0; n_ok = 1'b0; desat = 1'b0;
    failures = 0; tests_run = 0; rs = 32'd94113;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    step(3); chk(status, 1'b0); chk(neg_drv, 1'b1);
    @(posedge clk); p_ok <= 1'b1;
    step(5); chk(status, 1'b0);
    @(posedge clk); n_ok <= 1'b1;
    step(5); chk(status, 1'b1); chk(neg_drv, 1'b0);
    // Toggled commands at random spacing
    for (i = 0; i < 6; i++) begin
      rs = xs(rs);
      qe.push_back(~want);
      @(posedge clk); want <= ~want;
      step(5); chk(status, 1'b0);
      chk(gate_on, ~qe[0]);
      step(`GCF_TOFF_PROP_CYC + 2 + rs[2:0]); chk(status, 1'b1);
      chk(gate_on, qe.pop_front());
    end
    // Undervoltage with a command ignored
    @(posedge clk); want <= 1'b1;
    step(20); chk(gate_on, 1'b1);
    @(posedge clk); n_ok <= 1'b0;
    step(2); chk(gate_on, 1'b0); chk(neg_drv, 1'b1); chk(status, 1'b0);
    @(posedge clk); want <= 1'b0;
    step(20); chk(status, 1'b0);
    @(posedge clk); n_ok <= 1'b1;
    step(12); chk(status, 1'b1); chk(gate_on, 1'b0);
    // Short circuit at turn-on
    @(posedge clk); desat <= 1'b1; want <= 1'b1;
    step(22); chk(status, 1'b0);
    step(10); chk(gate_on, 1'b0);
    step(25); chk(status, 1'b1); chk(gate_on, 1'b0);
    @(posedge clk); desat <= 1'b0; want <= 1'b0;
    step(15);
    @(posedge clk); want <= 1'b1;
    step(15); chk(gate_on, 1'b1);
    end_sim;
  end
endmodule
`default_nettype wire
